//--- gca_pkg.sv
// Shared constants and types for the gauge control register block
package gca_pkg;
  // Control register field positions
  localparam int MODE_HI = 7;
  localparam int MODE_LO = 6;
  localparam int PRESC_HI = 5;
  localparam int PRESC_LO = 3;
  localparam int PIN_HI = 2;
  localparam int PIN_LO = 1;
  localparam int SHDN_BIT = 0;
  // Control register reset value: sleep, prescaler 111, alert mode, analog on
  localparam logic [7:0] CTRL_RESET = 8'h3C;
  // Conversion mode codes
  localparam logic [1:0] MODE_SLEEP = 2'h0;
  localparam logic [1:0] MODE_SINGLE = 2'h1;
  localparam logic [1:0] MODE_SCAN = 2'h2;
  localparam logic [1:0] MODE_CONT = 2'h3;
  // Pin configuration codes
  localparam logic [1:0] PIN_OFF = 2'h0;
  localparam logic [1:0] PIN_FULL_IN = 2'h1;
  localparam logic [1:0] PIN_ALERT = 2'h2;
  // Conversion selects in scan order
  localparam logic [1:0] SEL_VOLT = 2'h0;
  localparam logic [1:0] SEL_CURR = 2'h1;
  localparam logic [1:0] SEL_TEMP = 2'h2;
  // Charge counter values
  localparam logic [15:0] ACR_RESET = 16'h7FFF;
  localparam logic [15:0] ACR_FULL = 16'hFFFF;
  localparam logic [15:0] ACR_EMPTY = 16'h0000;
  localparam logic [12:0] RES_ZERO = 13'h0000;
  // Scan interval: the time in seconds and the core clock rate
  localparam int SCAN_PERIOD_S = 10;
  localparam int CLK_HZ = 25_000_000;
  localparam int SCAN_CYCLES = SCAN_PERIOD_S * CLK_HZ;
  localparam int SCAN_CNT_W = 28;
  // Sequencer states
  typedef enum logic [1:0] {SEQ_IDLE, SEQ_CONV, SEQ_SCAN_WAIT} gca_seq_state_t;
endpackage : gca_pkg

//--- gca_conv_seq.sv
// Conversion sequencer: runs voltage, current, temperature cycles by mode
module gca_conv_seq #(
  parameter int SCAN_WAIT_CYCLES = gca_pkg::SCAN_CYCLES
) (
  input wire logic clock_in,
  input wire logic reset_n_in,
  input wire logic [1:0] mode_in,
  input wire logic run_ok_in,
  input wire logic conv_done_in,
  output logic conv_start_out,
  output logic [1:0] conv_sel_out,
  output logic cycle_busy_out,
  output logic single_done_out
);
  gca_pkg::gca_seq_state_t state_r; // Sequencer state
  logic [1:0] cur_mode_r; // Mode latched when the cycle started
  logic [1:0] sel_r; // Quantity under conversion
  logic start_r; // One-cycle start to the converter
  logic single_done_r; // One-cycle end of a single cycle
  logic [gca_pkg::SCAN_CNT_W-1:0] wait_r; // Scan sleep counter
  localparam int SCAN_CNT_W = gca_pkg::SCAN_CNT_W;
  wire last_conv = conv_done_in && (sel_r == gca_pkg::SEL_TEMP);
  wire idle_go = run_ok_in && (mode_in != gca_pkg::MODE_SLEEP) && !single_done_r;
  wire wait_end = (wait_r == SCAN_CNT_W'(SCAN_WAIT_CYCLES - 1));

  assign conv_start_out = start_r;
  assign conv_sel_out = sel_r;
  assign cycle_busy_out = (state_r == gca_pkg::SEQ_CONV);
  assign single_done_out = single_done_r;

  // Mode is only sampled between cycles, so a rewrite never cuts a cycle short
  always_ff @(posedge clock_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      state_r <= gca_pkg::SEQ_IDLE;
      cur_mode_r <= gca_pkg::MODE_SLEEP;
      sel_r <= gca_pkg::SEL_VOLT;
      start_r <= 1'b0;
      single_done_r <= 1'b0;
      wait_r <= '0;
    end else begin
      start_r <= 1'b0;
      single_done_r <= 1'b0;
      case (state_r)
        gca_pkg::SEQ_IDLE: begin
          // Single done pulse blocks a restart until the field reads sleep
          if (idle_go) begin
            cur_mode_r <= mode_in;
            sel_r <= gca_pkg::SEL_VOLT;
            start_r <= 1'b1;
            state_r <= gca_pkg::SEQ_CONV;
          end
        end
        gca_pkg::SEQ_CONV: begin
          if (last_conv) begin
            if (cur_mode_r == gca_pkg::MODE_SINGLE) begin
              single_done_r <= 1'b1;
              state_r <= gca_pkg::SEQ_IDLE;
            end else if (mode_in == gca_pkg::MODE_SCAN) begin
              wait_r <= '0;
              state_r <= gca_pkg::SEQ_SCAN_WAIT;
            end else begin
              state_r <= gca_pkg::SEQ_IDLE;
            end
          end else if (conv_done_in) begin
            sel_r <= sel_r + 2'h1;
            start_r <= 1'b1;
          end
        end
        gca_pkg::SEQ_SCAN_WAIT: begin
          // Leaving scan or shutting down ends the sleep at once
          if (mode_in != gca_pkg::MODE_SCAN || !run_ok_in) begin
            state_r <= gca_pkg::SEQ_IDLE;
          end else if (wait_end) begin
            sel_r <= gca_pkg::SEL_VOLT;
            start_r <= 1'b1;
            state_r <= gca_pkg::SEQ_CONV;
          end else begin
            wait_r <= wait_r + SCAN_CNT_W'(1);
          end
        end
        default: state_r <= gca_pkg::SEQ_IDLE;
      endcase
    end
  end

  // A cycle's mode holds until its third conversion ends
  mode_held_a: assert property (@(posedge clock_in) disable iff (!reset_n_in)
    (state_r == gca_pkg::SEQ_CONV && !last_conv) |=> $stable(cur_mode_r))
    else $error("cycle mode changed inside a cycle");
  // A single cycle raises its done pulse right after the last conversion
  single_end_a: assert property (@(posedge clock_in) disable iff (!reset_n_in)
    (state_r == gca_pkg::SEQ_CONV && last_conv && cur_mode_r == gca_pkg::MODE_SINGLE)
    |=> single_done_r && state_r == gca_pkg::SEQ_IDLE)
    else $error("single cycle did not end");
  // Scan sleep counter starts from zero when the wait begins
  scan_wait_a: assert property (@(posedge clock_in) disable iff (!reset_n_in)
    (state_r == gca_pkg::SEQ_SCAN_WAIT && $past(state_r) == gca_pkg::SEQ_CONV) |-> wait_r == '0)
    else $error("scan sleep did not start from zero");
endmodule : gca_conv_seq

//--- gca_ctrl.sv
// Gauge control register with alert pin, charge counter and host crossing
module gca_ctrl #(
  parameter int SCAN_WAIT_CYCLES = gca_pkg::SCAN_CYCLES
) (
  input wire logic clock_in,
  input wire logic reset_n_in,
  input wire logic host_clk_in,
  input wire logic host_wr_in,
  input wire logic [7:0] host_wdata_in,
  output logic host_busy_out,
  output logic [7:0] host_rdata_out,
  input wire logic ara_done_in,
  input wire logic conv_done_in,
  output logic conv_start_out,
  output logic [1:0] conv_sel_out,
  input wire logic alert_event_in,
  input wire logic charge_up_in,
  input wire logic charge_dn_in,
  input wire logic alert_or_full_pin_in,
  output logic alert_or_full_pin_out,
  output logic alert_or_full_pin_oe_n_out,
  output logic analog_pd_out,
  output logic [15:0] acr_out
);
  // Prescaler factor minus one, as a limit for the residue counter
  // Codes 6 and 7 share the largest factor, which is why the residue is 13 bits wide
  function automatic logic [12:0] presc_limit(input logic [2:0] code);
    logic [12:0] m;
    m = 13'h0001;
    case (code)
      3'h0: m = 13'h0001;
      3'h1: m = 13'h0004;
      3'h2: m = 13'h0010;
      3'h3: m = 13'h0040;
      3'h4: m = 13'h0100;
      3'h5: m = 13'h0400;
      default: m = 13'h1000;
    endcase
    return m - 13'h0001;
  endfunction : presc_limit

  // ---------------- Host clock side ----------------
  logic wr_tgl_r; // Toggles once per accepted host write
  logic [7:0] wdata_hold_r; // Write data held stable until acknowledged
  logic ack_s1_r; // Write acknowledge synchroniser, first stage
  logic ack_s2_r; // Write acknowledge synchroniser, second stage
  logic ara_tgl_r; // Toggles once per completed alert response
  logic snap_s1_r; // Readback toggle synchroniser, first stage
  logic snap_s2_r; // Readback toggle synchroniser, second stage
  logic snap_s3_r; // Readback toggle history for edge detection
  logic [7:0] rdata_r; // Host copy of the control register
  // Core-side words that the host side samples, so they are declared here
  logic ack_tgl_r; // Core echo of the write toggle
  logic [7:0] snap_r; // Value offered to the host side
  logic snap_tgl_r; // Toggles when a new snapshot is offered

  assign host_busy_out = (wr_tgl_r != ack_s2_r);
  assign host_rdata_out = rdata_r;

  // Accept a write only when the previous one has been taken by the core
  always_ff @(posedge host_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      wr_tgl_r <= 1'b0;
      wdata_hold_r <= gca_pkg::CTRL_RESET;
      ara_tgl_r <= 1'b0;
    end else begin
      if (host_wr_in && !host_busy_out) begin
        wr_tgl_r <= ~wr_tgl_r;
        wdata_hold_r <= host_wdata_in;
      end
      if (ara_done_in) begin
        ara_tgl_r <= ~ara_tgl_r;
      end
    end
  end

  // Readback copy and acknowledge synchronisers on the host clock
  // The snapshot is held until echoed, so the host never takes a torn byte
  always_ff @(posedge host_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      ack_s1_r <= 1'b0;
      ack_s2_r <= 1'b0;
      snap_s1_r <= 1'b0;
      snap_s2_r <= 1'b0;
      snap_s3_r <= 1'b0;
      rdata_r <= gca_pkg::CTRL_RESET;
    end else begin
      ack_s1_r <= ack_tgl_r;
      ack_s2_r <= ack_s1_r;
      snap_s1_r <= snap_tgl_r;
      snap_s2_r <= snap_s1_r;
      snap_s3_r <= snap_s2_r;
      // Snapshot is held by the core until this side echoes the toggle
      if (snap_s2_r != snap_s3_r) begin
        rdata_r <= snap_r;
      end
    end
  end

  // ---------------- Core clock side ----------------
  logic [7:0] ctrl_r; // The control register
  logic [7:0] ctrl_nxt;
  logic wr_s1_r; // Write toggle synchroniser, first stage
  logic wr_s2_r; // Write toggle synchroniser, second stage
  logic ara_s1_r; // Alert response toggle, first stage
  logic ara_s2_r; // Alert response toggle, second stage
  logic ara_s3_r; // Alert response toggle history for edge detection
  logic sack_s1_r; // Readback echo, first stage
  logic sack_s2_r; // Readback echo, second stage
  logic pin_s1_r; // Pin input, first stage; resets high like the pull-up
  logic pin_s2_r; // Pin input, second stage
  logic alert_pend_r; // Alert latched and driving the pin
  logic [15:0] acr_r; // Accumulated charge counter
  logic [15:0] acr_nxt;
  logic [12:0] res_r; // Signed sub-LSB residue of the prescaler
  logic [12:0] res_nxt;
  logic conv_busy; // A conversion cycle is running
  logic single_done; // Single cycle finished, clear the mode field

  // Field decode
  wire [1:0] mode_f = ctrl_r[gca_pkg::MODE_HI:gca_pkg::MODE_LO];
  wire [2:0] presc_f = ctrl_r[gca_pkg::PRESC_HI:gca_pkg::PRESC_LO];
  wire [1:0] pin_f = ctrl_r[gca_pkg::PIN_HI:gca_pkg::PIN_LO];
  wire shdn_f = ctrl_r[gca_pkg::SHDN_BIT];
  // Clock crossing strobes, one core cycle each
  wire host_wr = (wr_s2_r != ack_tgl_r);
  wire ara_done = (ara_s2_r != ara_s3_r);
  // Prescaler step: M ticks of one sign make one count
  wire [12:0] lim = presc_limit(presc_f);
  wire lim_neg_hit = ($signed(res_r) <= -$signed(lim));
  wire up_tick = charge_up_in && !charge_dn_in && !shdn_f;
  wire dn_tick = charge_dn_in && !charge_up_in && !shdn_f;
  wire acr_inc = up_tick && ($signed(res_r) >= $signed(lim));
  wire acr_dec = dn_tick && lim_neg_hit;
  wire acr_wrap = (acr_inc && acr_r == gca_pkg::ACR_FULL) || (acr_dec && acr_r == gca_pkg::ACR_EMPTY);
  // Pin function decode
  wire full_in = (pin_f == gca_pkg::PIN_FULL_IN) && !pin_s2_r;
  wire alert_set = (pin_f == gca_pkg::PIN_ALERT) && (alert_event_in || acr_wrap);
  wire snap_free = (snap_tgl_r == sack_s2_r) && (snap_r != ctrl_r);

  // Register next value: a host write wins over the single-mode clear
  always_comb begin
    ctrl_nxt = ctrl_r;
    if (host_wr) begin
      ctrl_nxt = wdata_hold_r;
    end else if (single_done) begin
      ctrl_nxt[gca_pkg::MODE_HI:gca_pkg::MODE_LO] = gca_pkg::MODE_SLEEP;
    end
  end

  // Charge counter and residue; shutdown freezes the count and drops residue
  always_comb begin
    acr_nxt = acr_r;
    res_nxt = res_r;
    if (shdn_f) begin
      res_nxt = gca_pkg::RES_ZERO;
    end else if (acr_inc || acr_dec) begin
      res_nxt = gca_pkg::RES_ZERO;
      acr_nxt = acr_inc ? acr_r + 16'h0001 : acr_r - 16'h0001;
    end else if (up_tick) begin
      res_nxt = res_r + 13'h0001;
    end else if (dn_tick) begin
      res_nxt = res_r - 13'h0001;
    end
    // Full-charge load comes last so that it also works in shutdown
    if (full_in) begin
      acr_nxt = gca_pkg::ACR_FULL;
    end
  end

  // Synchronisers on the core clock
  // Each host-side crossing carries one toggle bit, so a late sample only delays the event
  always_ff @(posedge clock_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      wr_s1_r <= 1'b0;
      wr_s2_r <= 1'b0;
      ack_tgl_r <= 1'b0;
      ara_s1_r <= 1'b0;
      ara_s2_r <= 1'b0;
      ara_s3_r <= 1'b0;
      sack_s1_r <= 1'b0;
      sack_s2_r <= 1'b0;
      pin_s1_r <= 1'b1;
      pin_s2_r <= 1'b1;
    end else begin
      wr_s1_r <= wr_tgl_r;
      wr_s2_r <= wr_s1_r;
      ack_tgl_r <= wr_s2_r;
      ara_s1_r <= ara_tgl_r;
      ara_s2_r <= ara_s1_r;
      ara_s3_r <= ara_s2_r;
      sack_s1_r <= snap_s3_r;
      sack_s2_r <= sack_s1_r;
      pin_s1_r <= alert_or_full_pin_in;
      pin_s2_r <= pin_s1_r;
    end
  end

  // Control state on the core clock
  always_ff @(posedge clock_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      ctrl_r <= gca_pkg::CTRL_RESET;
      snap_r <= gca_pkg::CTRL_RESET;
      snap_tgl_r <= 1'b0;
      alert_pend_r <= 1'b0;
      acr_r <= gca_pkg::ACR_RESET;
      res_r <= gca_pkg::RES_ZERO;
    end else begin
      ctrl_r <= ctrl_nxt;
      acr_r <= acr_nxt;
      res_r <= res_nxt;
      // Offer a new readback only after the last one was echoed
      if (snap_free) begin
        snap_r <= ctrl_r;
        snap_tgl_r <= ~snap_tgl_r;
      end
      // New alert wins over a response in the same cycle; pin field changes do not clear
      if (alert_set) begin
        alert_pend_r <= 1'b1;
      end else if (ara_done) begin
        alert_pend_r <= 1'b0;
      end
    end
  end

  // Pin is driven low only by a pending alert; otherwise released and, unless in
  // full-charge mode, its level is not looked at
  assign alert_or_full_pin_out = 1'b0;
  assign alert_or_full_pin_oe_n_out = ~alert_pend_r;
  assign analog_pd_out = shdn_f;
  assign acr_out = acr_r;

  // Sequencer on the core clock; shutdown blocks new cycles, never a running one
  gca_conv_seq #(
    .SCAN_WAIT_CYCLES(SCAN_WAIT_CYCLES)
  ) u_seq (
    .clock_in(clock_in),
    .reset_n_in(reset_n_in),
    .mode_in(mode_f),
    .run_ok_in(!shdn_f),
    .conv_done_in(conv_done_in),
    .conv_start_out(conv_start_out),
    .conv_sel_out(conv_sel_out),
    .cycle_busy_out(conv_busy),
    .single_done_out(single_done)
  );

  // Alert pulls the pin within one cycle of its cause in alert mode
  alert_pull_a: assert property (@(posedge clock_in) disable iff (!reset_n_in)
    alert_set |=> !alert_or_full_pin_oe_n_out)
    else $error("alert did not pull the pin");
  // Pin stays driven until a response arrives, whatever the pin field does
  alert_hold_a: assert property (@(posedge clock_in) disable iff (!reset_n_in)
    (alert_pend_r && !ara_done) |=> alert_pend_r)
    else $error("alert released without a response");
  // Response with no new cause releases the pin
  ara_release_a: assert property (@(posedge clock_in) disable iff (!reset_n_in)
    (ara_done && !alert_set) |=> alert_or_full_pin_oe_n_out)
    else $error("alert response did not release the pin");
  // Shutdown holds the counter and keeps the residue empty
  shdn_freeze_a: assert property (@(posedge clock_in) disable iff (!reset_n_in)
    (shdn_f && !full_in) |=> $stable(acr_r) && res_r == gca_pkg::RES_ZERO)
    else $error("charge counted during shutdown");
  // Full-charge input loads the top value
  full_load_a: assert property (@(posedge clock_in) disable iff (!reset_n_in)
    full_in |=> acr_r == gca_pkg::ACR_FULL)
    else $error("full-charge input did not load counter");
  // Single done returns the mode field to sleep
  mode_clear_a: assert property (@(posedge clock_in) disable iff (!reset_n_in)
    (single_done && !host_wr) |=> mode_f == gca_pkg::MODE_SLEEP)
    else $error("mode not cleared after single cycle");
  // Disabled pin is neither driven nor read once no alert is pending
  pin_off_a: assert property (@(posedge clock_in) disable iff (!reset_n_in)
    (pin_f == gca_pkg::PIN_OFF && !alert_pend_r) |-> alert_or_full_pin_oe_n_out && !full_in)
    else $error("disabled pin driven or read");
  // Shutdown outside a cycle starts no conversion
  shdn_nostart_a: assert property (@(posedge clock_in) disable iff (!reset_n_in)
    (shdn_f && !conv_busy) |=> !conv_start_out)
    else $error("conversion started in shutdown");
  // An upward step moves the counter by exactly one
  count_up_a: assert property (@(posedge clock_in) disable iff (!reset_n_in)
    (acr_inc && !full_in) |=> acr_r == $past(acr_r) + 16'h0001)
    else $error("counter did not step up by one");
  // A host write lands whole in the register
  write_land_a: assert property (@(posedge clock_in) disable iff (!reset_n_in)
    host_wr |=> ctrl_r == $past(wdata_hold_r))
    else $error("host write did not land");
endmodule : gca_ctrl

//--- gca_far_model.sv
// Far-side model: converter that answers starts, plus charger and pull-up on the pin
module gca_far_model (
  input wire logic clock_in,
  input wire logic conv_start_in,
  input wire logic slow_in,
  input wire logic charger_full_in,
  input wire logic pin_drive_in,
  input wire logic pin_oe_n_in,
  output logic conv_done_out,
  output logic pin_level_out
);
  timeunit 1ns;
  timeprecision 100ps;
  // Open-drain wire with pull-up; a full charger pulls it low when nobody drives
  assign pin_level_out = !pin_oe_n_in ? pin_drive_in : !charger_full_in;
  // Each start is finished after a short or long delay, never twice
  initial begin
    conv_done_out = 1'b0;
    forever begin
      // Start is looked at mid-cycle, where it is settled; done lasts one cycle
      @(negedge clock_in);
      conv_done_out = 1'b0;
      if (conv_start_in === 1'b1) begin
        // Slow answers give the host time to see the written mode
        repeat (slow_in ? 20 : 2) @(posedge clock_in);
        @(negedge clock_in);
        conv_done_out = 1'b1;
      end
    end
  end
endmodule : gca_far_model

//--- gca_tb_top.sv
// Self-checking bench for the gauge control register block
module tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int SW = 20; // Short scan wait keeps the run brief
  logic clk, hclk, rst_n, wr, ara, done, ev, cu, cd, pin, slow, full;
  logic [7:0] wd;
  wire busy, start, pout, oe_n, pd;
  wire [7:0] rd;
  wire [1:0] sel;
  wire [15:0] accumulated_charge_counter;
  logic [15:0] exp_acr; // Expected charge counter
  logic [1:0] exp_sel;
  int error_cnt, n_checks, cyc, scnt, i, m;
  int times[64];
  bit up;

  gca_ctrl #(.SCAN_WAIT_CYCLES(SW)) dut_u (.clock_in(clk), .reset_n_in(rst_n), .host_clk_in(hclk),
    .host_wr_in(wr), .host_wdata_in(wd), .host_busy_out(busy), .host_rdata_out(rd), .ara_done_in(ara),
    .conv_done_in(done), .conv_start_out(start), .conv_sel_out(sel), .alert_event_in(ev),
    .charge_up_in(cu), .charge_dn_in(cd), .alert_or_full_pin_in(pin), .alert_or_full_pin_out(pout),
    .alert_or_full_pin_oe_n_out(oe_n), .analog_pd_out(pd), .acr_out(accumulated_charge_counter));
  gca_far_model far_u (.clock_in(clk), .conv_start_in(start), .slow_in(slow), .charger_full_in(full),
    .pin_drive_in(pout), .pin_oe_n_in(oe_n), .conv_done_out(done), .pin_level_out(pin));

  // Core clock 40 ns; link clock 6 ns with an odd phase offset
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  initial begin
    hclk = 1'b0;
    #1.7;
    forever #3 hclk = ~hclk;
  end

  // Compare and count; report at once on mismatch
  task automatic chk(input logic [15:0] seen, input logic [15:0] expv);
    n_checks++;
    if (seen !== expv) begin
      error_cnt++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, expv);
    end
  endtask : chk

  // Verdict and end of run
  task automatic end_sim();
    $display("checks=%0d errors=%0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : end_sim

  // Cycle count and a hang limit well above the expected length
  always @(posedge clk) begin
    cyc++;
    if (cyc == 60000) begin
      error_cnt++;
      end_sim();
    end
  end

  // Every start pulse must carry the next select in scan order
  always @(negedge clk) begin
    if (start === 1'b1) begin
      chk({14'h0, sel}, {14'h0, exp_sel});
      if (scnt < 64) times[scnt] = cyc;
      scnt++;
      exp_sel = (exp_sel == 2'h2) ? 2'h0 : exp_sel + 2'h1;
    end
  end

  // One host write; waits out busy, then the readback of the new value
  task automatic hwr(input logic [7:0] d);
    int k;
    for (k = 0; k < 100 && busy !== 1'b0; k++) @(negedge hclk);
    @(negedge hclk);
    wr = 1'b1;
    wd = d;
    @(negedge hclk);
    wr = 1'b0;
    chk({15'h0, busy}, 16'h0001);
    for (k = 0; k < 200 && (busy !== 1'b0 || rd !== d); k++) @(negedge hclk);
    chk({8'h0, rd}, {8'h0, d});
  endtask : hwr

  // Charge ticks in one direction, then settle
  task automatic ticks(input int n, input bit u);
    repeat (n) begin
      @(negedge clk);
      cu = u;
      cd = !u;
      @(negedge clk);
      cu = 1'b0;
      cd = 1'b0;
    end
    repeat (5) @(negedge clk);
  endtask : ticks

  // Bounded wait for the alert output to reach a level
  task automatic wait_oe(input logic v);
    int k;
    for (k = 0; k < 20 && oe_n !== v; k++) @(negedge clk);
    chk({15'h0, oe_n}, {15'h0, v});
  endtask : wait_oe

  task automatic pulse_ev();
    @(negedge clk);
    ev = 1'b1;
    @(negedge clk);
    ev = 1'b0;
    repeat (6) @(negedge clk);
  endtask : pulse_ev

  task automatic pulse_ara();
    @(negedge hclk);
    ara = 1'b1;
    @(negedge hclk);
    ara = 1'b0;
  endtask : pulse_ara

  // Main sequence
  initial begin
    {wr, ara, ev, cu, cd, slow, full} = '0;
    wd = 8'h00;
    exp_sel = 2'h0;
    exp_acr = 16'h7FFF;
    rst_n = 1'b0;
    void'($urandom(32'hd2b1));
    repeat (8) @(negedge clk);
    rst_n = 1'b1;
    repeat (4) @(negedge clk);
    // Reset state of register and outputs
    chk({8'h0, rd}, 16'h003C);
    chk({15'h0, oe_n}, 16'h0001);
    chk({15'h0, pd}, 16'h0000);
    chk(accumulated_charge_counter, exp_acr);
    // Random writes with sleep mode and a legal pin code
    repeat (4) begin
      wd = 8'($urandom) & 8'h3F;
      if (wd[2:1] == 2'b11) wd[2:1] = 2'b00;
      hwr(wd);
      chk({15'h0, pd}, {15'h0, wd[0]});
    end
    // Every prescaler code: M-1 ticks leave the counter, one more moves it
    for (i = 0; i < 8; i++) begin
      hwr({2'b00, i[2:0], 3'b000});
      m = (i >= 6) ? 4096 : (1 << (2 * i));
      up = 1'($urandom);
      ticks(m - 1, up);
      chk(accumulated_charge_counter, exp_acr);
      ticks(1, up);
      exp_acr = up ? exp_acr + 16'h1 : exp_acr - 16'h1;
      chk(accumulated_charge_counter, exp_acr);
    end
    // Shutdown freezes counting and drops the partial step
    hwr(8'h08);
    ticks(2, 1'b1);
    hwr(8'h09);
    chk({15'h0, pd}, 16'h0001);
    ticks(5, 1'b1);
    chk(accumulated_charge_counter, exp_acr);
    hwr(8'h08);
    ticks(3, 1'b1);
    chk(accumulated_charge_counter, exp_acr);
    ticks(1, 1'b1);
    exp_acr = exp_acr + 16'h1;
    chk(accumulated_charge_counter, exp_acr);
    // Single set of conversions, then the mode clears itself
    slow = 1'b1;
    scnt = 0;
    hwr(8'h40);
    for (i = 0; i < 400 && rd !== 8'h00; i++) @(negedge clk);
    chk({8'h0, rd}, 16'h0000);
    chk(16'(scnt), 16'h0003);
    // Continuous, then sleep written in mid-cycle: only whole cycles run
    slow = 1'b0;
    hwr(8'hC0);
    repeat (37) @(negedge clk);
    hwr(8'h00);
    repeat (60) @(negedge clk);
    chk(16'(scnt % 3), 16'h0000);
    m = scnt;
    repeat (60) @(negedge clk);
    chk(16'(scnt), 16'(m));
    // Scan mode repeats after the wait
    scnt = 0;
    hwr(8'h80);
    for (i = 0; i < 400 && scnt < 6; i++) @(negedge clk);
    chk(16'(scnt), 16'h0006);
    chk(16'(times[3] - times[2] >= SW), 16'h0001);
    chk({8'h0, rd}, 16'h0080);
    hwr(8'h00);
    repeat (60) @(negedge clk);
    // Shutdown blocks new cycles
    m = scnt;
    hwr(8'hC1);
    repeat (60) @(negedge clk);
    chk(16'(scnt), 16'(m));
    hwr(8'h00);
    // Alert set, kept over a pin field change, released by response
    hwr(8'h04);
    pulse_ev();
    chk({15'h0, oe_n}, 16'h0000);
    chk({15'h0, pin}, 16'h0000);
    hwr(8'h00);
    repeat (10) @(negedge clk);
    chk({15'h0, oe_n}, 16'h0000);
    pulse_ara();
    wait_oe(1'b1);
    // Disabled pin: no alert, input level ignored
    pulse_ev();
    chk({15'h0, oe_n}, 16'h0001);
    full = 1'b1;
    repeat (8) @(negedge clk);
    chk(accumulated_charge_counter, exp_acr);
    full = 1'b0;
    // Full-charge input loads the maximum
    hwr(8'h02);
    full = 1'b1;
    repeat (8) @(negedge clk);
    exp_acr = 16'hFFFF;
    chk(accumulated_charge_counter, exp_acr);
    chk({15'h0, oe_n}, 16'h0001);
    full = 1'b0;
    repeat (4) @(negedge clk);
    // Counter wrap in alert mode raises the alert
    hwr(8'h04);
    ticks(1, 1'b1);
    exp_acr = 16'h0000;
    chk(accumulated_charge_counter, exp_acr);
    chk({15'h0, oe_n}, 16'h0000);
    pulse_ara();
    wait_oe(1'b1);
    end_sim();
  end
endmodule : tb_top
